// >>> asp_pkg.sv
// Package for the angle sensor serial port: frame layout, commands, timing.
// Assumes a 250 MHz core clock; included before all design modules.
package asp_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          SAMPLE_PERIOD_NS = 1000;
  localparam int          SAMPLE_CYCLES    =
    (SAMPLE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int          NVM_WAIT_MS      = 20;
  localparam int          NVM_WAIT_CYCLES  =
    (NVM_WAIT_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int          FILT_K_DEFAULT   = 4;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int          FRAME_BITS   = 16;
  localparam int          ANGLE_BITS   = 14;
  localparam int          ADDR_BITS    = 5;
  localparam int          DATA_BITS    = 8;
  localparam int          NUM_REGS     = 32;
  localparam int          CMD_MSB      = 15;
  localparam int          CMD_LSB      = 13;
  localparam int          ADDR_MSB     = 12;
  localparam int          ADDR_LSB     = 8;
  localparam logic [2:0]  CMD_READ     = 3'h2;
  localparam logic [2:0]  CMD_WRITE    = 3'h4;
  localparam logic [4:0]  BIT_CNT_FULL = 5'h10;

  // ****************************************************************
  // Configuration registers used by the angle path
  // ****************************************************************
  localparam logic [4:0]  REG_ZERO_LO  = 5'h00;
  localparam logic [4:0]  REG_ZERO_HI  = 5'h01;
  localparam logic [4:0]  REG_FILT     = 5'h0E;
  localparam logic [4:0]  REG_DIR      = 5'h09;
  localparam int          DIR_BIT      = 7;

  typedef enum logic [1:0] {
    ASP_RESP_ANGLE,
    ASP_RESP_REG,
    ASP_RESP_WAIT
  } asp_resp_t;

endpackage

// >>> asp_fifo.sv
// Small valid/ready FIFO carrying angle samples to the serial port.
// Assumes one clock domain and an asynchronous active low reset.
`timescale 1ns/1ps
module asp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  // Write side
  input  wire logic             wr_valid_in,
  output      logic             wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // Read side
  output      logic             rd_valid_out,
  input  wire logic             rd_ready_in,
  output      logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = wr_valid_in && wr_ready_out;
  wire              pop  = rd_valid_out && rd_ready_in;

  assign wr_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_reg != '0);
  assign rd_data_out  = mem_reg[rd_ptr_reg];

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> asp_top.sv
// Serial port of the angle sensor: sampler, filter, register store, slave.
// Assumes link pins come from outside; they are synchronised to ref_clk_in.
`timescale 1ns/1ps
module asp_top #(
  parameter int NVM_CYCLES = asp_pkg::NVM_WAIT_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  // Raw field phase from the front-end
  input  wire logic [asp_pkg::ANGLE_BITS-1:0] raw_angle_in,
  // Serial link
  input  wire logic cs_b_in,
  input  wire logic sclk_in,
  input  wire logic mosi_in,
  output      logic miso_out,
  output      logic miso_oe_out
);
  import asp_pkg::*;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [1:0] cs_sync_reg, sclk_sync_reg, mosi_sync_reg;
  logic       cs_last_reg, sclk_last_reg;
  wire        cs_b   = cs_sync_reg[1];
  wire        sclk   = sclk_sync_reg[1];
  wire        mosi   = mosi_sync_reg[1];
  wire        cs_fall = cs_last_reg && !cs_b;
  wire        cs_rise = !cs_last_reg && cs_b;
  // Mode 3 starts with clock high: its first edge is falling, ignored
  wire        sclk_rise = !cs_b && !sclk_last_reg && sclk;
  wire        sclk_fall = !cs_b && sclk_last_reg && !sclk;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs_sync_reg   <= 2'h3;
      sclk_sync_reg <= 2'h0;
      mosi_sync_reg <= 2'h0;
      cs_last_reg   <= 1'b1;
      sclk_last_reg <= 1'b0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[0], cs_b_in};
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
      cs_last_reg   <= cs_b;
      sclk_last_reg <= sclk;
    end
  end

  // ****************************************************************
  // Sampler and filter
  // ****************************************************************
  localparam int SW = $clog2(SAMPLE_CYCLES);
  localparam int FW = ANGLE_BITS + 16;
  logic [SW-1:0]          samp_cnt_reg;
  logic signed [FW-1:0]   acc1_reg, acc2_reg;
  logic [NUM_REGS*DATA_BITS-1:0] regs_flat;
  wire  samp_tick = (samp_cnt_reg == SW'(SAMPLE_CYCLES-1));
  wire  [3:0] filt_k = (regs_flat[REG_FILT*DATA_BITS +: 4] == 4'h0) ?
                       4'(FILT_K_DEFAULT) : regs_flat[REG_FILT*DATA_BITS +: 4];
  wire  signed [FW-1:0] x_in = FW'({raw_angle_in, 16'h0000});
  // Two cascaded leaky integrators on angle error plus velocity feed
  wire  signed [FW-1:0] err1 = x_in - acc1_reg;
  wire  signed [FW-1:0] err2 = acc1_reg - acc2_reg;
  wire  [ANGLE_BITS-1:0] filt_out =
    ANGLE_BITS'((acc1_reg + acc1_reg - acc2_reg) >>> 16);

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      samp_cnt_reg <= '0;
      acc1_reg     <= '0;
      acc2_reg     <= '0;
    end else begin
      samp_cnt_reg <= samp_tick ? '0 : samp_cnt_reg + 1'b1;
      if (samp_tick) begin
        acc1_reg <= acc1_reg + (err1 >>> filt_k);
        acc2_reg <= acc2_reg + (err2 >>> filt_k);
      end
    end
  end

  // Direction and zero offset
  wire [15:0] zero_pos = {regs_flat[REG_ZERO_HI*DATA_BITS +: 8],
                          regs_flat[REG_ZERO_LO*DATA_BITS +: 8]};
  wire        dir_ccw  = regs_flat[REG_DIR*DATA_BITS + DIR_BIT];
  wire [15:0] ang_full = {filt_out, 2'h0};
  wire [15:0] ang_dir  = dir_ccw ? (16'h0000 - ang_full) : ang_full;
  wire [15:0] ang_rep  = ang_dir - zero_pos;

  // ****************************************************************
  // Sample FIFO feeding the output buffer
  // ****************************************************************
  logic        fifo_rd_valid;
  logic [15:0] fifo_rd_data;
  logic [15:0] out_buf_reg;
  wire         frozen = !cs_b;
  wire         fifo_pop = !frozen;

  asp_fifo #(.WIDTH(16), .DEPTH(4)) u_fifo (
    .ref_clk_in   (ref_clk_in),
    .rst_b_in     (rst_b_in),
    .wr_valid_in  (samp_tick),
    .wr_ready_out (),
    .wr_data_in   ({ang_rep[15:2], 2'h0}),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_pop),
    .rd_data_out  (fifo_rd_data)
  );

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  logic [4:0]             bit_cnt_reg;
  logic [FRAME_BITS-1:0]  rx_reg, tx_reg;
  logic [DATA_BITS-1:0]   regs_mem [NUM_REGS];
  asp_resp_t              resp_reg;
  logic [ADDR_BITS-1:0]   resp_addr_reg;
  logic [31:0]            nvm_cnt_reg;
  logic                   miso_reg;

  wire [FRAME_BITS-1:0] rx_full = {rx_reg[FRAME_BITS-2:0], mosi};
  wire frame_done = sclk_rise && (bit_cnt_reg == BIT_CNT_FULL - 5'h01);
  wire [2:0] cmd  = rx_full[CMD_MSB:CMD_LSB];
  wire [ADDR_BITS-1:0] addr = rx_full[ADDR_MSB:ADDR_LSB];
  wire is_read  = frame_done && (cmd == CMD_READ);
  wire is_write = frame_done && (cmd == CMD_WRITE);
  wire nvm_busy = (nvm_cnt_reg != 32'h0);
  wire [FRAME_BITS-1:0] load_word =
    (resp_reg == ASP_RESP_ANGLE) ? out_buf_reg :
    (resp_reg == ASP_RESP_REG) ?
      {regs_mem[resp_addr_reg], 8'h00} : 16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_flat
      assign regs_flat[gi*DATA_BITS +: DATA_BITS] = regs_mem[gi];
    end
  endgenerate

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_buf_reg <= 16'h0000;
    end else if (fifo_pop && fifo_rd_valid) begin
      out_buf_reg <= fifo_rd_data;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_mem[i] <= '0;
      end
    end else if (is_write) begin
      regs_mem[addr] <= rx_full[DATA_BITS-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt_reg   <= '0;
      rx_reg        <= '0;
      tx_reg        <= '0;
      resp_reg      <= ASP_RESP_ANGLE;
      resp_addr_reg <= '0;
      nvm_cnt_reg   <= '0;
      miso_reg      <= 1'b0;
      miso_oe_out   <= 1'b0;
    end else begin
      miso_oe_out <= !cs_b;
      if (nvm_busy) begin
        nvm_cnt_reg <= nvm_cnt_reg - 32'h1;
      end
      if (nvm_busy && resp_reg == ASP_RESP_WAIT &&
          nvm_cnt_reg == 32'h1) begin
        resp_reg <= ASP_RESP_REG;
      end
      if (cs_rise) begin
        bit_cnt_reg <= '0;
        rx_reg      <= '0;
      end else if (cs_fall) begin
        tx_reg   <= load_word << 1;
        miso_reg <= load_word[FRAME_BITS-1];
        if (resp_reg == ASP_RESP_REG) begin
          resp_reg <= ASP_RESP_ANGLE;
        end
      end else begin
        if (sclk_rise && bit_cnt_reg != BIT_CNT_FULL) begin
          rx_reg      <= rx_full;
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        if (sclk_fall && bit_cnt_reg != 5'h00) begin
          miso_reg <= tx_reg[FRAME_BITS-1];
          tx_reg   <= tx_reg << 1;
        end
        if (is_read) begin
          resp_reg      <= ASP_RESP_REG;
          resp_addr_reg <= addr;
        end else if (is_write) begin
          resp_reg      <= ASP_RESP_WAIT;
          resp_addr_reg <= addr;
          nvm_cnt_reg   <= 32'(NVM_CYCLES);
        end
      end
    end
  end

  assign miso_out = miso_reg;

  wire [DATA_BITS-1:0] wr_val = rx_full[DATA_BITS-1:0];

  chk_frame_reset : assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) cs_rise |=> bit_cnt_reg == 5'h00)
    else $error("bit counter not cleared on chip select rise");
  chk_buf_freeze : assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) (frozen && $past(frozen)) |->
      $stable(out_buf_reg))
    else $error("output buffer changed while frozen");
  chk_sample_rate : assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) samp_tick |=> !samp_tick [*8])
    else $error("samples too close");
  chk_write_store : assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) is_write |=> regs_mem[$past(addr)] ==
      $past(wr_val))
    else $error("write value not stored");
  chk_read_resp : assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) is_read && !cs_rise && !cs_fall |=>
      resp_reg == ASP_RESP_REG)
    else $error("read request not armed");
  chk_miso_hold : assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) !cs_b && !sclk_fall && !cs_fall |=>
      $stable(miso_reg))
    else $error("miso moved without falling clock");
  chk_tail_zero : assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) cs_fall && resp_reg == ASP_RESP_ANGLE |=>
      tx_reg[2:0] == 3'h0)
    else $error("angle padding not zero");
  chk_oe_follow : assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) !cs_b |=> miso_oe_out)
    else $error("miso not driven in frame");
endmodule

// >>> asp_spi_master.sv
// Behavioural serial master that drives the sensor port pins.
// Assumes callers start each frame just after a falling core clock edge.
`timescale 1ns/1ps
module asp_spi_master (
  // Serial link
  output      logic cs_b_out,
  output      logic sclk_out,
  output      logic mosi_out,
  input  wire logic miso_in
);
  localparam time HALF = 24ns;

  initial begin
    cs_b_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end

  // ****************************************************************
  // One frame of nb clocks, MSB first, idle level from the mode
  // ****************************************************************
  task automatic xfer(input bit m3, input int nb, input logic [15:0] tx,
                      output logic [15:0] rx);
    rx = 16'h0000;
    sclk_out = m3;
    #(32*HALF);
    cs_b_out = 1'b0;
    mosi_out = tx[15];
    #(4*HALF);
    for (int i = 0; i < nb; i++) begin
      if (m3 || i > 0) begin
        sclk_out = 1'b0;
        mosi_out = tx[15-i];
        #HALF;
      end
      sclk_out = 1'b1;
      rx = {rx[14:0], miso_in};
      #HALF;
    end
    sclk_out = m3;
    #(2*HALF);
    cs_b_out = 1'b1;
    mosi_out = 1'b0;
  endtask
endmodule

// >>> tb_asp_top.sv
// Self-checking bench for the angle sensor serial port.
// Assumes the master model on the far side and a 250 MHz core clock.
`timescale 1ns/1ps
module tb_asp_top;
  import asp_pkg::*;
  localparam int NVM = 100;

  logic        clk     = 1'b0;
  logic        rst_b   = 1'b0;
  logic [13:0] raw     = 14'h0000;
  wire         cs_b;
  wire         sclk;
  wire         mosi;
  wire         miso;
  wire         miso_oe;
  wire         miso_w;
  logic [15:0] rx;
  logic [15:0] d;
  logic [7:0]  v;
  logic [4:0]  a;
  int          n_errors = 0;
  int          n_checks = 0;
  int          seed     = 32'h2cc8;

  always #2 clk = ~clk;
  assign miso_w = miso_oe ? miso : 1'bz;

  asp_top #(.NVM_CYCLES(NVM)) asp_top_i (
    .ref_clk_in  (clk),
    .rst_b_in    (rst_b),
    .raw_angle_in(raw),
    .cs_b_in     (cs_b),
    .sclk_in     (sclk),
    .mosi_in     (mosi),
    .miso_out    (miso),
    .miso_oe_out (miso_oe)
  );

  asp_spi_master asp_spi_master_i (
    .cs_b_out(cs_b),
    .sclk_out(sclk),
    .mosi_out(mosi),
    .miso_in (miso_w)
  );

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************************
  // Frame helpers
  // ****************************************************************
  task automatic frame(input bit m3, input int nb, input logic [15:0] tx);
    @(negedge clk);
    asp_spi_master_i.xfer(m3, nb, tx, rx);
    repeat (8) @(negedge clk);
    check("oe_idle", {15'h0000, miso_oe}, 16'h0000);
  endtask

  task automatic wr(input bit m3, input logic [4:0] ad, input logic [7:0] dv);
    frame(m3, 16, {CMD_WRITE, ad, dv});
    repeat (NVM + 20) @(negedge clk);
    frame(!m3, 16, 16'h0000);
    check("write_ack", rx, {dv, 8'h00});
  endtask

  function automatic logic [15:0] exp_angle(input int c, input logic [13:0] r);
    if (c == 1) begin
      return 16'h0000 - {r, 2'h0};
    end
    return {r, 2'h0} - ((c == 2) ? 16'h4000 : 16'h0000);
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(negedge clk);
    check("oe_reset", {15'h0000, miso_oe}, 16'h0000);
    rst_b = 1'b1;
    repeat (260) @(negedge clk);
    wr(1'b0, REG_FILT, 8'h01);
    for (int i = 0; i < 6; i++) begin
      a = 5'h10 | 5'($random(seed));
      v = 8'($random(seed));
      wr(i[0], a, v);
      frame(i[1], 8, 16'hFFFF);
      check("short_idle", rx, 16'h0000);
      frame(!i[0], 16, {CMD_READ, a, 8'h00});
      frame(i[0], 16, 16'h0000);
      check("read_value", rx, {v, 8'h00});
    end
    $display("test registers done");
    for (int c = 0; c < 3; c++) begin
      wr(1'b0, REG_DIR, (c == 1) ? 8'h80 : 8'h00);
      wr(1'b1, REG_ZERO_HI, (c == 2) ? 8'h40 : 8'h00);
      for (int m = 0; m < 2; m++) begin
        @(negedge clk);
        raw = 14'h1800 + 14'($random(seed) & 32'h0FFF);
        repeat (8000) @(negedge clk);
        frame(m[0], 16, 16'h0000);
        d = rx - exp_angle(c, raw);
        check("angle_pad", {14'h0000, rx[1:0]}, 16'h0000);
        check("angle_near", {15'h0000, (d < 16'h0080 || d > 16'hFF80)},
              16'h0001);
        frame(!m[0], 16, 16'h0000);
        d = rx - exp_angle(c, raw);
        check("angle_again", {15'h0000, (d < 16'h0080 || d > 16'hFF80)},
              16'h0001);
        frame(m[0], 12, 16'h0000);
        d = rx - (exp_angle(c, raw) >> 4);
        check("angle_short", {15'h0000, (d < 16'h0008 || d > 16'hFFF8)},
              16'h0001);
      end
      $display("test angle case %0d done", c);
    end
    give_verdict();
  end

  initial begin
    #360us;
    n_errors++;
    give_verdict();
  end
endmodule
